// file: mth_consts.svh
// constants for the measurement trigger handshake block
`ifndef MTH_CONSTS_SVH
`define MTH_CONSTS_SVH

// clock and timing
`define MTH_CLK_HZ 25000000
`define MTH_HZ_PER_MHZ 1000000
`define MTH_CYC_PER_US (`MTH_CLK_HZ / `MTH_HZ_PER_MHZ)
`define MTH_PRE_W 5
`define MTH_DLY_W 16

// apb register byte offsets
`define MTH_ADDR_W 12
`define MTH_OFF_CTRL 12'h000
`define MTH_OFF_STATUS 12'h004
`define MTH_OFF_IRQ_STAT 12'h008
`define MTH_OFF_IRQ_MASK 12'h00C

// control register layout
`define MTH_CTRL_DLY_LSB 0
`define MTH_CTRL_DLY_MSB 15
`define MTH_CTRL_CLR_BIT 16
`define MTH_CTRL_RETRIG_BIT 17
`define MTH_CTRL_RISE_BIT 18
`define MTH_CTRL_DLY_RST 16'h0000
`define MTH_CTRL_CLR_RST 1'b1
`define MTH_CTRL_RETRIG_RST 1'b0
`define MTH_CTRL_RISE_RST 1'b0

// interrupt bits
`define MTH_IRQ_W 3
`define MTH_IRQ_DONE 0
`define MTH_IRQ_ERR 1
`define MTH_IRQ_IGN 2

// judgement and error widths
`define MTH_CMP_W 6
`define MTH_BIN_W 10
`define MTH_JDG_W 16
`define MTH_ERR_W 5

// open-drain pin vector layout
`define MTH_OD_W 19
`define MTH_OD_EOM 0
`define MTH_OD_INDEX 1
`define MTH_OD_ERR 2
`define MTH_OD_JDG_LSB 3
`define MTH_OD_JDG_MSB 18

`endif

// file: mth_delay_tmr.sv
// judgement-to-end-strobe delay timer in microsecond steps
`timescale 1ns/1ps
`default_nettype none
`include "mth_consts.svh"
module mth_delay_tmr (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// carrier
	mth_measure_trigger_if.tmr_side tif
);
	logic busy_r;
	logic [`MTH_PRE_W-1:0] pre_r;
	logic [`MTH_DLY_W-1:0] cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
			pre_r <= '0;
			cnt_r <= '0;
			tif.tmr_expired <= 1'b0;
		end else begin
			tif.tmr_expired <= 1'b0;
			if (tif.tmr_load) begin
				busy_r <= 1'b1;
				pre_r <= '0;
				cnt_r <= tif.tmr_dly_us;
			end else if (busy_r) begin
				if (cnt_r == '0) begin
					busy_r <= 1'b0;
					tif.tmr_expired <= 1'b1;
				end else if (pre_r == `MTH_PRE_W'(`MTH_CYC_PER_US - 1)) begin
					pre_r <= '0;
					cnt_r <= cnt_r - 1'b1;
				end else begin
					pre_r <= pre_r + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: mth_measure_trigger_edge.sv
// trigger pin synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none
`include "mth_consts.svh"
module mth_measure_trigger_edge (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// trigger pin, low while asserted
	input wire logic measure_trigger_n,
	// carrier
	mth_measure_trigger_if.edge_side tif
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// idle pin level is high, so preload high to avoid a false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			meta_r <= measure_trigger_n;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tif.measure_trigger_pulse <= 1'b0;
		end else begin
			tif.measure_trigger_pulse <= tif.edge_rise ? (sync_r & ~prev_r) : (~sync_r & prev_r);
		end
	end
endmodule
`default_nettype wire

// file: mth_measure_trigger_if.sv
// carrier between the control logic, trigger edge finder and delay timer
`timescale 1ns/1ps
`default_nettype none
`include "mth_consts.svh"
interface mth_measure_trigger_if;
	logic edge_rise;
	logic measure_trigger_pulse;
	logic tmr_load;
	logic [`MTH_DLY_W-1:0] tmr_dly_us;
	logic tmr_expired;
	modport edge_side (input edge_rise, output measure_trigger_pulse);
	modport tmr_side (input tmr_load, input tmr_dly_us, output tmr_expired);
	modport ctl_side (output edge_rise, input measure_trigger_pulse, output tmr_load,
		output tmr_dly_us, input tmr_expired);
endinterface
`default_nettype wire

// file: mth_pkg.sv
// types for the measurement trigger handshake block
`default_nettype none
package mth_pkg;
	typedef enum logic [1:0] {
		MTH_IDLE,
		MTH_MEAS,
		MTH_HOLD
	} mth_state_e;
endpackage
`default_nettype wire

// file: mth_plc_model.sv
// controller model: drives the trigger pin, watches the end strobe
`timescale 1ns/1ps
`default_nettype none
`include "mth_consts.svh"
module mth_plc_model #(
	parameter int PULSE_CYC = 2500,
	parameter int GAP_CYC = 10000
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench command
	input wire logic fire,
	output logic busy,
	// device pins
	input wire logic [`MTH_OD_W-1:0] od_o,
	input wire logic [`MTH_OD_W-1:0] od_oe,
	output logic measure_trigger_n
);
	int low_r;
	int gap_r;
	logic eom_q_r;
	logic eom_wire;
	// pulled up while the device releases it
	assign eom_wire = od_oe[`MTH_OD_EOM] ? od_o[`MTH_OD_EOM] : 1'b1;
	assign busy = (low_r != 0) || (gap_r != 0);
	assign measure_trigger_n = (low_r != 0) ? 1'b0 : 1'b1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_r <= 0;
		end else if (fire && !busy) begin
			low_r <= PULSE_CYC;
		end else if (low_r != 0) begin
			low_r <= low_r - 1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_r <= 0;
			eom_q_r <= 1'b1;
		end else begin
			eom_q_r <= eom_wire;
			if (eom_q_r && !eom_wire) begin
				gap_r <= GAP_CYC;
			end else if (gap_r != 0) begin
				gap_r <= gap_r - 1;
			end
		end
	end
endmodule
`default_nettype wire

// file: mth_top.sv
// measurement trigger handshake: external port strobes, judgements, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "mth_consts.svh"
module mth_top
	import mth_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`MTH_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// trigger pin, low while asserted
	input wire logic measure_trigger_n,
	// measurement core, same clock
	output logic meas_start,
	input wire logic acq_done,
	input wire logic meas_done,
	input wire logic [`MTH_CMP_W-1:0] judge_cmp,
	input wire logic [`MTH_BIN_W-1:0] judge_bin_sort,
	input wire logic [`MTH_ERR_W-1:0] err_src,
	// open-drain pins: end strobe, acquisition done, error, judgements
	output logic [`MTH_OD_W-1:0] od_o,
	output logic [`MTH_OD_W-1:0] od_oe,
	// interrupt
	output logic irq
);
	mth_measure_trigger_if tif ();

	mth_state_e state_r;
	logic [`MTH_DLY_W-1:0] dly_us_r;
	logic clr_on_start_r;
	logic retrig_en_r;
	logic edge_rise_r;
	logic eom_act_r;
	logic index_act_r;
	logic err_act_r;
	logic [`MTH_ERR_W-1:0] err_cause_r;
	logic [`MTH_JDG_W-1:0] judge_act_r;
	logic [`MTH_IRQ_W-1:0] irq_stat_r;
	logic [`MTH_IRQ_W-1:0] irq_mask_r;
	logic [`MTH_IRQ_W-1:0] irq_set;
	logic tmr_load_r;
	logic busy;
	logic start;
	logic ignore;
	logic finish;
	logic apb_setup;
	logic apb_wr;
	logic apb_rd;
	logic hit;
	logic [31:0] rd_nxt;

	mth_measure_trigger_edge u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.measure_trigger_n(measure_trigger_n),
		.tif(tif)
	);

	mth_delay_tmr u_tmr (
		.pclk(pclk),
		.presetn(presetn),
		.tif(tif)
	);

	assign tif.edge_rise = edge_rise_r;
	assign tif.tmr_load = tmr_load_r;
	assign tif.tmr_dly_us = dly_us_r;

	// measuring means the end strobe is released (high)
	assign busy = (state_r != MTH_IDLE);
	assign start = tif.measure_trigger_pulse & (~busy | retrig_en_r);
	assign ignore = tif.measure_trigger_pulse & busy & ~retrig_en_r;
	assign finish = meas_done & (state_r == MTH_MEAS) & ~start;

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= MTH_IDLE;
			tmr_load_r <= 1'b0;
		end else begin
			tmr_load_r <= 1'b0;
			case (state_r)
				MTH_IDLE: begin
					if (start) begin
						state_r <= MTH_MEAS;
					end
				end
				MTH_MEAS: begin
					if (finish) begin
						state_r <= MTH_HOLD;
						tmr_load_r <= 1'b1;
					end
				end
				MTH_HOLD: begin
					if (start) begin
						state_r <= MTH_MEAS;
					end else if (tif.tmr_expired && !tmr_load_r) begin
						state_r <= MTH_IDLE;
					end
				end
				default: begin
					state_r <= MTH_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_start <= 1'b0;
		end else begin
			meas_start <= start;
		end
	end

	// end strobe only after the delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eom_act_r <= 1'b0;
			index_act_r <= 1'b0;
		end else if (start) begin
			eom_act_r <= 1'b0;
			index_act_r <= 1'b0;
		end else begin
			if (state_r == MTH_HOLD && tif.tmr_expired && !tmr_load_r) begin
				eom_act_r <= 1'b1;
			end
			if (acq_done && busy) begin
				index_act_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			judge_act_r <= '0;
			err_act_r <= 1'b0;
			err_cause_r <= '0;
		end else if (start && clr_on_start_r) begin
			judge_act_r <= '0;
			err_act_r <= 1'b0;
		end else if (finish) begin
			judge_act_r <= {judge_bin_sort, judge_cmp};
			err_act_r <= |err_src;
			err_cause_r <= err_src;
		end
	end

	// asserted means sinking: enable high, level low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			od_o <= '0;
			od_oe <= '0;
		end else begin
			od_o <= '0;
			od_oe <= {judge_act_r, err_act_r, index_act_r, eom_act_r};
		end
	end

	// apb slave, zero wait states
	// pready one cycle after setup; prdata then holds until the next setup
	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite & pready;
	assign apb_rd = psel & penable & ~pwrite & pready;
	assign hit = (paddr == `MTH_OFF_CTRL) || (paddr == `MTH_OFF_STATUS) ||
		(paddr == `MTH_OFF_IRQ_STAT) || (paddr == `MTH_OFF_IRQ_MASK);

	always_comb begin
		rd_nxt = '0;
		case (paddr)
			`MTH_OFF_CTRL: begin
				rd_nxt[`MTH_CTRL_DLY_MSB:`MTH_CTRL_DLY_LSB] = dly_us_r;
				rd_nxt[`MTH_CTRL_CLR_BIT] = clr_on_start_r;
				rd_nxt[`MTH_CTRL_RETRIG_BIT] = retrig_en_r;
				rd_nxt[`MTH_CTRL_RISE_BIT] = edge_rise_r;
			end
			`MTH_OFF_STATUS: begin
				rd_nxt = 32'({judge_act_r, err_cause_r, err_act_r, index_act_r,
					eom_act_r, state_r});
			end
			`MTH_OFF_IRQ_STAT: begin
				rd_nxt = 32'(irq_stat_r);
			end
			`MTH_OFF_IRQ_MASK: begin
				rd_nxt = 32'(irq_mask_r);
			end
			default: begin
				rd_nxt = '0;
			end
		endcase
	end

	// reads never stall the trigger path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~hit;
			if (apb_setup) begin
				prdata <= rd_nxt;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_us_r <= `MTH_CTRL_DLY_RST;
			clr_on_start_r <= `MTH_CTRL_CLR_RST;
			retrig_en_r <= `MTH_CTRL_RETRIG_RST;
			edge_rise_r <= `MTH_CTRL_RISE_RST;
			irq_mask_r <= '0;
		end else if (apb_wr) begin
			if (paddr == `MTH_OFF_CTRL) begin
				dly_us_r <= pwdata[`MTH_CTRL_DLY_MSB:`MTH_CTRL_DLY_LSB];
				clr_on_start_r <= pwdata[`MTH_CTRL_CLR_BIT];
				retrig_en_r <= pwdata[`MTH_CTRL_RETRIG_BIT];
				edge_rise_r <= pwdata[`MTH_CTRL_RISE_BIT];
			end
			if (paddr == `MTH_OFF_IRQ_MASK) begin
				irq_mask_r <= pwdata[`MTH_IRQ_W-1:0];
			end
		end
	end

	// interrupt status: read clears, a new event wins
	always_comb begin
		irq_set = '0;
		irq_set[`MTH_IRQ_DONE] = state_r == MTH_HOLD && tif.tmr_expired && !tmr_load_r;
		irq_set[`MTH_IRQ_ERR] = finish & (|err_src);
		irq_set[`MTH_IRQ_IGN] = ignore;
	end

	// irq lags status by a cycle so it leaves straight from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
			irq <= 1'b0;
		end else begin
			if (apb_rd && paddr == `MTH_OFF_IRQ_STAT) begin
				irq_stat_r <= irq_set;
			end else begin
				irq_stat_r <= irq_stat_r | irq_set;
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// checks
	sequence s_judged;
		finish ##1 (state_r == MTH_HOLD);
	endsequence

	sequence s_strobe_low;
		$rose(eom_act_r);
	endsequence

	a_eom_after_delay: assert property (@(posedge pclk) disable iff (!presetn)
		s_strobe_low |-> $past(tif.tmr_expired) && $past(state_r) == MTH_HOLD)
		else $error("end strobe asserted without delay expiry");

	a_clear_judge: assert property (@(posedge pclk) disable iff (!presetn)
		start && clr_on_start_r |=> judge_act_r == '0 && !err_act_r)
		else $error("judgements not cleared at start");

	a_keep_judge: assert property (@(posedge pclk) disable iff (!presetn)
		start && !clr_on_start_r && !finish |=> $stable(judge_act_r))
		else $error("judgements changed at start while kept");

	a_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		tif.measure_trigger_pulse && busy && !retrig_en_r |=> !meas_start && irq_stat_r[`MTH_IRQ_IGN])
		else $error("trigger during measurement not ignored");

	a_edge_start: assert property (@(posedge pclk) disable iff (!presetn)
		tif.measure_trigger_pulse && state_r == MTH_IDLE |=> meas_start && state_r == MTH_MEAS)
		else $error("idle trigger edge did not start");

	a_judge_update: assert property (@(posedge pclk) disable iff (!presetn)
		s_judged |-> judge_act_r == $past({judge_bin_sort, judge_cmp}, 1))
		else $error("judgements not updated at finish");

	a_err_flag: assert property (@(posedge pclk) disable iff (!presetn)
		finish && (|err_src) |=> err_act_r ##1 od_oe[`MTH_OD_ERR])
		else $error("error flag not raised");

	a_od_sink: assert property (@(posedge pclk) disable iff (!presetn)
		(od_o == '0) and (eom_act_r |=> od_oe[`MTH_OD_EOM]))
		else $error("open-drain pin drives high");

	a_strobes_high: assert property (@(posedge pclk) disable iff (!presetn)
		meas_start |-> !eom_act_r && !index_act_r ##1 !od_oe[`MTH_OD_EOM])
		else $error("strobes not released at start");

	// a bus read does not block a trigger
	a_read_free: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rd && tif.measure_trigger_pulse && !busy |=> meas_start)
		else $error("trigger lost during bus read");
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the measurement trigger handshake
`timescale 1ns/1ps
`default_nettype none
`include "mth_consts.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic meas_start, acq_done, meas_done, measure_trigger_n, irq, fire, busy;
	logic [`MTH_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [`MTH_CMP_W-1:0] judge_cmp;
	logic [`MTH_BIN_W-1:0] judge_bin_sort;
	logic [`MTH_ERR_W-1:0] err_src;
	logic [`MTH_OD_W-1:0] od_o, od_oe;
	int bad_count, n_compared, cyc, k;
	mth_top mth_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .measure_trigger_n(measure_trigger_n), .meas_start(meas_start),
		.acq_done(acq_done), .meas_done(meas_done), .judge_cmp(judge_cmp),
		.judge_bin_sort(judge_bin_sort), .err_src(err_src), .od_o(od_o), .od_oe(od_oe),
		.irq(irq));
	mth_plc_model mth_plc_model_inst (.pclk(pclk), .presetn(presetn), .fire(fire),
		.busy(busy), .od_o(od_o), .od_oe(od_oe), .measure_trigger_n(measure_trigger_n));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// run length is about 41000 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			bad_count = bad_count + 1;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [`MTH_ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the cycle ceiling ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [`MTH_ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	// wait out the controller, fire, then look for the start pulse
	task automatic measure_trigger(input logic exp);
		for (k = 0; k < 20000 && busy !== 1'b0; k++) @(posedge pclk);
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		for (k = 0; k < 3000 && meas_start !== 1'b1; k++) @(posedge pclk);
		chk(32'(meas_start), 32'(exp));
	endtask
	task automatic finish_meas(input logic [5:0] c, input logic [9:0] b, input logic [4:0] e,
		input int d);
		int t0;
		acq_done <= 1'b1;
		@(posedge pclk);
		acq_done <= 1'b0;
		judge_cmp <= c;
		judge_bin_sort <= b;
		err_src <= e;
		meas_done <= 1'b1;
		@(posedge pclk);
		meas_done <= 1'b0;
		t0 = -1;
		for (k = 0; k < 2000 && od_oe[0] !== 1'b1; k++) begin
			@(posedge pclk);
			if (t0 < 0 && od_oe[18:2] === {b, c, |e})
				t0 = k;
		end
		chk(32'(k - t0 >= d * `MTH_CYC_PER_US && k - t0 <= d * `MTH_CYC_PER_US + 4),
			32'h0000_0001);
		chk(32'(od_oe), 32'({b, c, |e, 2'b11}));
		chk(32'(od_o), 32'h0000_0000);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, acq_done, meas_done, fire} = '0;
		paddr = '0;
		pwdata = '0;
		judge_cmp = '0;
		judge_bin_sort = '0;
		err_src = '0;
		bad_count = 0;
		n_compared = 0;
		cyc = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(`MTH_OFF_CTRL, 32'h0001_0000);
		chk(32'(od_oe), 32'h0000_0000);
		rdc(12'h010, 32'h0000_0000);
		chk(32'(slv), 32'h0000_0001);
		apb(1'b1, `MTH_OFF_CTRL, 32'h0001_0002);
		measure_trigger(1'b1);
		apb(1'b0, `MTH_OFF_STATUS, 32'h0000_0000);
		chk(32'(rd[1:0]), 32'h0000_0001);
		finish_meas(6'h15, 10'h201, 5'h01, 2);
		chk(32'(irq), 32'h0000_0000);
		apb(1'b1, `MTH_OFF_IRQ_MASK, 32'h0000_0007);
		// irq follows the status one cycle late
		@(posedge pclk);
		chk(32'(irq), 32'h0000_0001);
		rdc(`MTH_OFF_IRQ_STAT, 32'h0000_0003);
		@(posedge pclk);
		chk(32'(irq), 32'h0000_0000);
		measure_trigger(1'b1);
		repeat (3) @(posedge pclk);
		chk(32'(od_oe), 32'h0000_0000);
		measure_trigger(1'b0);
		chk(32'(irq), 32'h0000_0001);
		rdc(`MTH_OFF_IRQ_STAT, 32'h0000_0004);
		finish_meas(6'h0A, 10'h1FE, 5'h02, 2);
		rdc(`MTH_OFF_IRQ_STAT, 32'h0000_0003);
		apb(1'b1, `MTH_OFF_CTRL, 32'h0006_0001);
		measure_trigger(1'b1);
		chk(32'(k >= 2500), 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk(32'(od_oe), 32'({10'h1FE, 6'h0A, 1'b1, 2'b00}));
		measure_trigger(1'b1);
		finish_meas(6'h33, 10'h0C3, 5'h04, 1);
		apb(1'b1, `MTH_OFF_CTRL, 32'h0001_0000);
		measure_trigger(1'b1);
		finish_meas(6'h01, 10'h001, 5'h18, 0);
		complete_run();
	end
endmodule
`default_nettype wire
